//--- logic/address_generator_map.vh
`ifndef ADDRESS_GENERATOR_MAP_VH
`define ADDRESS_GENERATOR_MAP_VH
`define CIRC_MODE_CONTROL_OFS  16'h0046
`define X_BUF_START_OFS        16'h0048
`define X_BUF_END_OFS          16'h004a
`define Y_BUF_START_OFS        16'h004c
`define Y_BUF_END_OFS          16'h004e
`define BIT_REVERSE_CTRL_OFS   16'h0900
`define CIRC_MODE_RESET        16'h0000
`define X_BUF_START_RESET      16'h0000
`define X_BUF_END_RESET        16'h0001
`define Y_BUF_START_RESET      16'h0000
`define Y_BUF_END_RESET        16'h0001
`define BIT_REVERSE_RESET      16'h0000
`define X_CIRC_ENABLE_BIT      15
`define Y_CIRC_ENABLE_BIT      14
`define BITREV_SEL_LSB         8
`define Y_CIRC_SEL_LSB         4
`define X_CIRC_SEL_LSB         0
`define BIT_REVERSE_ENABLE_BIT 15
`define CIRC_MODE_WRITE_MASK   16'hcfff
`endif

//--- logic/data_address_generator_pair.v
`timescale 1ns/100ps
`default_nettype none
`include "address_generator_map.vh"
module data_address_generator_pair
(
  // Clock and reset.
  input  wire        core_clk_i,
  input  wire        reset_i,
  // Register port.
  input  wire [15:0] reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_write_i,
  input  wire        reg_read_i,
  output reg  [15:0] reg_rdata_o,
  // X request from instruction execution.
  input  wire        x_req_i,
  input  wire [3:0]  x_ptr_sel_i,
  input  wire [15:0] x_ptr_i,
  input  wire [15:0] x_step_i,
  input  wire        x_prog_space_i,
  input  wire        x_byte_i,
  // Y request from instruction execution.
  input  wire        y_req_i,
  input  wire [3:0]  y_ptr_sel_i,
  input  wire [15:0] y_ptr_i,
  input  wire [15:0] y_step_i,
  input  wire        y_mac_read_i,
  // X results.
  output reg  [15:0] x_ea_o,
  output reg  [15:0] x_ptr_next_o,
  output reg         x_valid_o,
  output reg         x_wrapped_o,
  // Y results.
  output reg  [15:0] y_ea_o,
  output reg  [15:0] y_ptr_next_o,
  output reg         y_valid_o,
  output reg         y_wrapped_o,
  output wire        y_refused_o
);

  reg  [15:0] circ_mode_reg;
  reg  [15:0] x_start_reg;
  reg  [15:0] x_end_reg;
  reg  [15:0] y_start_reg;
  reg  [15:0] y_end_reg;
  reg  [15:0] bitrev_reg;
  reg  [15:0] rdata_next;
  wire        x_circ_enable;
  wire        y_circ_enable;
  wire        bit_reverse_enable;
  wire [3:0]  x_circular_pointer_select;
  wire [3:0]  y_circular_pointer_select;
  wire [3:0]  bitrev_pointer_select;
  wire        x_use_circ;
  wire        y_use_circ;
  wire        x_use_brev;
  wire        y_accept;
  wire [15:0] x_lin_next;
  wire [15:0] y_lin_next;
  wire        x_wrap;
  wire        y_wrap;
  reg  [15:0] x_next;
  reg  [15:0] y_ptr_word;
  reg  [15:0] y_step_word;
  wire        wr_circ_mode;
  wire        wr_x_start;
  wire        wr_x_end;
  wire        wr_y_start;
  wire        wr_y_end;
  wire        wr_bitrev;
  wire        x_sel_circ;
  wire        y_sel_circ;
  wire        x_sel_brev;

  // Bit-reversed add: carry ripples from the most significant bit downward.
  function [15:0] rev16;
    input [15:0] v;
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1)
        rev16[k] = v[15 - k];
    end
  endfunction

  function [15:0] brev_add;
    input [15:0] ptr;
    input [14:0] mod;
    begin
      brev_add = rev16(rev16(ptr) + rev16({1'b0, mod}));
    end
  endfunction

  // One comparator shape serves the write decode of every register.
  function addr_hit;
    input [15:0] addr;
    input [15:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // Buffer bounds are kept on word edges: starts even, ends odd.
  function [15:0] with_lsb;
    input [15:0] value;
    input        lsb;
    begin
      with_lsb = {value[15:1], lsb};
    end
  endfunction

  function pointer_match;
    input [3:0] sel;
    input [3:0] field;
    begin
      pointer_match = (sel == field);
    end
  endfunction

  assign x_circ_enable             = circ_mode_reg[`X_CIRC_ENABLE_BIT];
  assign y_circ_enable             = circ_mode_reg[`Y_CIRC_ENABLE_BIT];
  assign bitrev_pointer_select     = circ_mode_reg[`BITREV_SEL_LSB +: 4];
  assign y_circular_pointer_select = circ_mode_reg[`Y_CIRC_SEL_LSB +: 4];
  assign x_circular_pointer_select = circ_mode_reg[`X_CIRC_SEL_LSB +: 4];
  assign bit_reverse_enable        = bitrev_reg[`BIT_REVERSE_ENABLE_BIT];

  assign x_sel_circ = pointer_match(x_ptr_sel_i, x_circular_pointer_select);
  assign y_sel_circ = pointer_match(y_ptr_sel_i, y_circular_pointer_select);
  assign x_sel_brev = pointer_match(x_ptr_sel_i, bitrev_pointer_select);

  // Write strobes are decoded once per register.
  assign wr_circ_mode = reg_write_i && addr_hit(reg_addr_i, `CIRC_MODE_CONTROL_OFS);
  assign wr_x_start   = reg_write_i && addr_hit(reg_addr_i, `X_BUF_START_OFS);
  assign wr_x_end     = reg_write_i && addr_hit(reg_addr_i, `X_BUF_END_OFS);
  assign wr_y_start   = reg_write_i && addr_hit(reg_addr_i, `Y_BUF_START_OFS);
  assign wr_y_end     = reg_write_i && addr_hit(reg_addr_i, `Y_BUF_END_OFS);
  assign wr_bitrev    = reg_write_i && addr_hit(reg_addr_i, `BIT_REVERSE_CTRL_OFS);

  // Circular mode applies in either space with the same mechanism.
  assign x_use_circ = x_circ_enable && x_sel_circ;
  assign y_use_circ = y_circ_enable && y_sel_circ;
  // Bit reversal never touches program-space addresses and outranks circular mode.
  assign x_use_brev = bit_reverse_enable && !x_prog_space_i && !x_byte_i &&
                      x_sel_brev;
  // Y only serves word reads of multiply-accumulate class instructions.
  assign y_accept    = y_req_i && y_mac_read_i;
  assign y_refused_o = y_req_i && !y_mac_read_i;

  always @*
  begin
    y_ptr_word  = {y_ptr_i[15:1], 1'b0};
    y_step_word = {y_step_i[15:1], 1'b0};
  end

  // Two independent update paths work in the same cycle.
  pointer_update u_x_update
  (
    .ptr_i     (x_ptr_i),
    .step_i    (x_step_i),
    .circ_en_i (x_use_circ),
    .start_i   (x_start_reg),
    .end_i     (x_end_reg),
    .next_o    (x_lin_next),
    .wrapped_o (x_wrap)
  );

  // Y bounds sit on word edges, matching the word-only Y path.
  pointer_update u_y_update
  (
    .ptr_i     (y_ptr_word),
    .step_i    (y_step_word),
    .circ_en_i (y_use_circ),
    .start_i   (with_lsb(y_start_reg, 1'b0)),
    .end_i     (with_lsb(y_end_reg, 1'b1)),
    .next_o    (y_lin_next),
    .wrapped_o (y_wrap)
  );

  always @*
  begin
    if (x_use_brev)
      x_next = brev_add(x_ptr_i, bitrev_reg[14:0]);
    else
      x_next = x_lin_next;
  end

  // Unmapped addresses read as zero.
  always @*
  begin
    case (reg_addr_i)
      `CIRC_MODE_CONTROL_OFS: rdata_next = circ_mode_reg;
      `X_BUF_START_OFS:       rdata_next = x_start_reg;
      `X_BUF_END_OFS:         rdata_next = x_end_reg;
      `Y_BUF_START_OFS:       rdata_next = y_start_reg;
      `Y_BUF_END_OFS:         rdata_next = y_end_reg;
      `BIT_REVERSE_CTRL_OFS:  rdata_next = bitrev_reg;
      default:                rdata_next = 16'h0000;
    endcase
  end

  // Each register has its own process, so a write disturbs no other flop group.
  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      circ_mode_reg <= `CIRC_MODE_RESET;
    else if (wr_circ_mode)
      circ_mode_reg <= reg_wdata_i & `CIRC_MODE_WRITE_MASK;
  end

  // Start registers hold bit 0 at zero and end registers at one.
  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      x_start_reg <= `X_BUF_START_RESET;
    else if (wr_x_start)
      x_start_reg <= with_lsb(reg_wdata_i, 1'b0);
  end

  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      x_end_reg <= `X_BUF_END_RESET;
    else if (wr_x_end)
      x_end_reg <= with_lsb(reg_wdata_i, 1'b1);
  end

  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      y_start_reg <= `Y_BUF_START_RESET;
    else if (wr_y_start)
      y_start_reg <= with_lsb(reg_wdata_i, 1'b0);
  end

  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      y_end_reg <= `Y_BUF_END_RESET;
    else if (wr_y_end)
      y_end_reg <= with_lsb(reg_wdata_i, 1'b1);
  end

  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      bitrev_reg <= `BIT_REVERSE_RESET;
    else if (wr_bitrev)
      bitrev_reg <= reg_wdata_i;
  end

  // Read data stand for one cycle and then return to zero, so nothing stale lingers.
  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_read_i)
      reg_rdata_o <= rdata_next;
    else
      reg_rdata_o <= 16'h0000;
  end

  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      x_ea_o       <= 16'h0000;
      x_ptr_next_o <= 16'h0000;
      x_valid_o    <= 1'b0;
      x_wrapped_o  <= 1'b0;
    end
    else
    begin
      x_valid_o <= x_req_i;
      // Address and update hold until the next request, so the core may take them late.
      if (x_req_i)
      begin
        x_ea_o       <= x_ptr_i;
        x_ptr_next_o <= x_next;
        x_wrapped_o  <= x_wrap && !x_use_brev;
      end
    end
  end

  always @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      y_ea_o       <= 16'h0000;
      y_ptr_next_o <= 16'h0000;
      y_valid_o    <= 1'b0;
      y_wrapped_o  <= 1'b0;
    end
    else
    begin
      y_valid_o <= y_accept;
      // A refused request leaves the last Y answer in place.
      if (y_accept)
      begin
        y_ea_o       <= y_ptr_word;
        y_ptr_next_o <= with_lsb(y_lin_next, 1'b0);
        y_wrapped_o  <= y_wrap;
      end
    end
  end

endmodule
`default_nettype wire

//--- logic/pointer_update.v
`timescale 1ns/100ps
`default_nettype none
`include "address_generator_map.vh"
module pointer_update
(
  // Pointer and modifier.
  input  wire [15:0] ptr_i,
  input  wire [15:0] step_i,
  // Circular window.
  input  wire        circ_en_i,
  input  wire [15:0] start_i,
  input  wire [15:0] end_i,
  // Result.
  output reg  [15:0] next_o,
  output wire        wrapped_o
);

  reg [15:0] sum;
  reg [16:0] len;
  reg        wrap;

  always @*
  begin
    sum  = ptr_i + step_i;
    len  = {1'b0, end_i} - {1'b0, start_i} + 17'h00001;
    wrap = 1'b0;
    next_o = sum;
    if (circ_en_i)
    begin
      // Both boundaries are checked, so a step of either sign wraps cleanly.
      if (!step_i[15] && (ptr_i <= end_i) && (sum > end_i))
      begin
        next_o = sum - len[15:0];
        wrap = 1'b1;
      end
      else if (step_i[15] && (ptr_i >= start_i) && (sum < start_i))
      begin
        next_o = sum + len[15:0];
        wrap = 1'b1;
      end
    end
  end

  assign wrapped_o = wrap;

endmodule
`default_nettype wire

//--- verification/core_ptr_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_ptr_model (
  input wire logic        clk_i, rst_i, load_i, x_valid_i, y_valid_i,
  input wire logic [15:0] x_load_i, y_load_i, x_next_i, y_next_i,
  output logic     [15:0] x_ptr_o, y_ptr_o
);
  // The execution stage writes each updated pointer back, so ops chain.
  always @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      x_ptr_o <= 16'h0000;
      y_ptr_o <= 16'h0000;
    end
    else
    begin
      x_ptr_o <= load_i ? x_load_i : x_valid_i ? x_next_i : x_ptr_o;
      y_ptr_o <= load_i ? y_load_i : y_valid_i ? y_next_i : y_ptr_o;
    end
endmodule
`default_nettype wire

//--- verification/data_address_generator_pair_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "address_generator_map.vh"
module dagp_checker (
  input wire logic core_clk_i, reset_i, reg_write_i, reg_read_i, x_req_i,
  input wire logic x_prog_space_i, y_req_i, y_mac_read_i, x_valid_o,
  input wire logic x_wrapped_o, y_valid_o, y_refused_o,
  input wire logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, x_ptr_i,
  input wire logic [15:0] x_step_i, x_ea_o, x_ptr_next_o, y_ea_o, y_ptr_next_o
);
  logic [15:0] ctl_reg;
  wire [15:0] x_sum = x_ptr_i + x_step_i;
  // Program space never takes the bit-reverse path, so a clear X enable is enough to make the update linear.
  wire x_lin = x_req_i && x_prog_space_i && !ctl_reg[`X_CIRC_ENABLE_BIT];
  always @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
      ctl_reg <= 16'h0000;
    else if (reg_write_i && reg_addr_i == `CIRC_MODE_CONTROL_OFS)
      ctl_reg <= reg_wdata_i & `CIRC_MODE_WRITE_MASK;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_y_take; y_req_i && y_mac_read_i; endsequence
  sequence s_y_refuse; y_req_i && !y_mac_read_i && y_refused_o; endsequence
  a_x_answer: assert property (x_req_i |=> x_valid_o)
    else $error("x answer missing");
  a_y_answer: assert property (s_y_take |=> y_valid_o)
    else $error("y answer missing");
  a_y_refuse: assert property (y_req_i && !y_mac_read_i |-> s_y_refuse ##1 !y_valid_o)
    else $error("y request not refused");
  a_y_word_only: assert property (y_valid_o |-> !y_ea_o[0] && !y_ptr_next_o[0])
    else $error("y address odd");
  a_x_ea_pointer: assert property (x_req_i |=> x_ea_o == $past(x_ptr_i))
    else $error("x address not pointer");
  a_x_linear_prog: assert property (x_lin |=> x_ptr_next_o == $past(x_sum))
    else $error("x linear update wrong");
  a_x_no_wrap: assert property (x_lin |=> !x_wrapped_o)
    else $error("x wrapped while linear");
  a_ctl_readback: assert property (reg_read_i && reg_addr_i == 16'h0046 |=> reg_rdata_o == ctl_reg)
    else $error("control readback wrong");
  a_rdata_idle: assert property (!reg_read_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not idle");
endmodule
bind data_address_generator_pair dagp_checker dagp_checker_inst (.*);
`default_nettype wire

//--- verification/data_address_generator_pair_tb.sv
`timescale 1ns/100ps
`default_nettype none
module data_address_generator_pair_tb;
  logic clk = 0, rst = 1, we = 0, re = 0, xr = 0, yr = 0, mac = 0, pr = 0, by = 0, ld = 0, rf;
  logic [3:0] xs = 4'h0, ys = 4'h2;
  logic [15:0] adr = 0, wd = 0, st = 0, lx = 0, ly = 0;
  wire [15:0] rdat, xp, yp, xea, xnx, yea, ynx;
  wire xv, xw, yv, yw, yrf;
  int mismatches = 0, total_checks = 0, cyc = 0, i;
  logic [15:0] ta [7] = '{16'h0046, 16'h0048, 16'h004a, 16'h004c, 16'h004e, 16'h0900, 16'h0050};
  logic [15:0] tv [7] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
  data_address_generator_pair data_address_generator_pair_inst (.core_clk_i(clk), .reset_i(rst),
    .reg_addr_i(adr), .reg_wdata_i(wd), .reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rdat),
    .x_req_i(xr), .x_ptr_sel_i(xs), .x_ptr_i(xp), .x_step_i(st), .x_prog_space_i(pr),
    .x_byte_i(by), .y_req_i(yr), .y_ptr_sel_i(ys), .y_ptr_i(yp), .y_step_i(st),
    .y_mac_read_i(mac), .x_ea_o(xea), .x_ptr_next_o(xnx), .x_valid_o(xv), .x_wrapped_o(xw),
    .y_ea_o(yea), .y_ptr_next_o(ynx), .y_valid_o(yv), .y_wrapped_o(yw), .y_refused_o(yrf));
  core_ptr_model core_ptr_model_inst (.clk_i(clk), .rst_i(rst), .load_i(ld), .x_valid_i(xv),
    .y_valid_i(yv), .x_load_i(lx), .y_load_i(ly), .x_next_i(xnx), .y_next_i(ynx),
    .x_ptr_o(xp), .y_ptr_o(yp));
  initial forever #25 clk = ~clk;
  always @(posedge clk)
    if (++cyc == 3000)
    begin
      mismatches++;
      conclude();
    end
  task chk(input logic [15:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [15:0] a, d);
    @(posedge clk);
    {adr, wd, we} <= {a, d, 1'b1};
    @(posedge clk);
    we <= 0;
  endtask
  task rd(input logic [15:0] a, e);
    @(posedge clk);
    {adr, re} <= {a, 1'b1};
    @(posedge clk);
    re <= 0;
    #1 chk(rdat, e);
  endtask
  task ldp(input logic [15:0] x, y);
    @(posedge clk);
    {lx, ly, ld} <= {x, y, 1'b1};
    @(posedge clk);
    ld <= 0;
  endtask
  task op(input logic x, y, m, p, b, input logic [15:0] s);
    @(posedge clk);
    {xr, yr, mac, pr, by, st} <= {x, y, m, p, b, s};
    #1 rf = yrf;
    @(posedge clk);
    {xr, yr} <= 2'b00;
    #1;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 7; i++) rd(ta[i], tv[i]);
    wr(16'h0046, 16'hffff);
    rd(16'h0046, 16'hcfff);
    wr(16'h0048, 16'h1001);
    rd(16'h0048, 16'h1000);
    wr(16'h004a, 16'h1006);
    rd(16'h004a, 16'h1007);
    wr(16'h004c, 16'h2000);
    wr(16'h004e, 16'h2007);
    wr(16'h0050, 16'h1234);
    rd(16'h0050, 16'h0000);
    $display("register test done");
    wr(16'h0046, 16'h0000);
    ldp(16'h1006, 16'h2006);
    op(1, 1, 1, 0, 0, 16'h0002);
    chk(xnx, 16'h1008);
    chk(ynx, 16'h2008);
    chk({15'h0, yw}, 16'h0000);
    chk({15'h0, xw}, 16'h0000);
    wr(16'h0046, 16'hc020);
    ldp(16'h1006, 16'h2006);
    op(1, 1, 1, 0, 0, 16'h0002);
    chk(xea, 16'h1006);
    chk({15'h0, xv}, 16'h0001);
    chk(xnx, 16'h1000);
    chk(ynx, 16'h2000);
    chk({15'h0, xw}, 16'h0001);
    chk({15'h0, yw}, 16'h0001);
    op(1, 1, 1, 1, 0, 16'hfffe);
    chk(xnx, 16'h1006);
    chk(ynx, 16'h2006);
    $display("circular test done");
    ldp(16'h0000, 16'h2003);
    op(0, 1, 0, 0, 0, 16'h0002);
    chk({15'h0, rf}, 16'h0001);
    chk({15'h0, yv}, 16'h0000);
    op(0, 1, 1, 0, 0, 16'h0002);
    chk(yea, 16'h2002);
    chk({15'h0, yv}, 16'h0001);
    chk(ynx, 16'h2004);
    $display("y space test done");
    wr(16'h0900, 16'h8008);
    wr(16'h0046, 16'h0100);
    xs <= 4'h1;
    ldp(16'h0008, 16'h0000);
    op(1, 0, 0, 0, 0, 16'h0002);
    chk(xnx, 16'h0004);
    op(1, 0, 0, 1, 0, 16'h0002);
    chk(xnx, 16'h0006);
    op(1, 0, 0, 0, 1, 16'h0001);
    chk(xnx, 16'h0007);
    $display("bit reverse test done");
    conclude();
  end
endmodule
`default_nettype wire
